// File: logic/timer_posted_read_sync.sv
/*
  Read-synchronization front end of a timer and its watchdog: holds the
  sync control bits, shadows functional-domain values into the interface
  domain, and answers posted and non-posted reads.
  Assumes the timer core supplies live values and a functional tick pulse,
  both synchronous to core_clk; counting and expiry live elsewhere.
  Posted and watchdog reads answer from the shadows one cycle after the
  request; non-posted reads wait for the next functional tick and answer
  with the live value, so the host must not poll faster than busy allows.
*/
module timer_posted_read_sync
  import timer_sync_pkg::*;
#(
  parameter bit READ_MODE_WRITE_ONLY = 1'b0 // instance has write-only read-mode bit
) (
  input wire logic core_clk, // interface clock, 100 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic iclk_active, // interface clock running, low while stopped
  input wire logic func_tick, // one functional clock edge
  input wire logic [DATA_W-1:0] timer_counter_in, // live counter
  input wire logic [DATA_W-1:0] capture_first_in, // live first capture
  input wire logic [DATA_W-1:0] capture_second_in, // live second capture
  input wire logic [DATA_W-1:0] watchdog_counter_in, // live watchdog counter
  input wire logic reg_rd, // read request pulse
  input wire logic reg_wr, // write request pulse
  input wire logic [SEL_W-1:0] reg_sel, // register select
  input wire logic [DATA_W-1:0] reg_wdata, // write data
  output logic [DATA_W-1:0] rd_data, // read data
  output logic rd_valid, // read data valid pulse
  output logic rd_unsettled, // answer came from an unsettled shadow
  output logic busy // non-posted read pending
);
  logic settled;
  logic posted_q, posted_d;
  logic read_mode_q, read_mode_d;
  logic [DATA_W-1:0] sh_cnt_q, sh_cnt_d;
  logic [DATA_W-1:0] sh_cap1_q, sh_cap1_d;
  logic [DATA_W-1:0] sh_cap2_q, sh_cap2_d;
  logic [DATA_W-1:0] sh_wdt_q, sh_wdt_d;
  rd_state_type state_q, state_d;
  logic [SEL_W-1:0] sel_q, sel_d;
  logic [DATA_W-1:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic unsettled_q, unsettled_d;
  logic busy_q, busy_d;
  logic ans_fire, ans_stale;
  logic [DATA_W-1:0] ans_value;

  function automatic logic [DATA_W-1:0] pick(input logic [SEL_W-1:0] sel,
      input logic [DATA_W-1:0] cnt, input logic [DATA_W-1:0] cap1,
      input logic [DATA_W-1:0] cap2, input logic [DATA_W-1:0] wdt);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case (sel)
      SEL_TIMER_COUNTER: v = cnt;
      SEL_CAPTURE_FIRST: v = cap1;
      SEL_CAPTURE_SECOND: v = cap2;
      SEL_WATCHDOG_COUNTER: v = wdt;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_view(input logic posted, input logic rmode);
    logic [DATA_W-1:0] v;
    v = '0;
    if (!READ_MODE_WRITE_ONLY) begin
      v[POSTED_BIT] = posted;
      v[READ_MODE_BIT] = rmode;
    end
    return v;
  endfunction

  wake_settle u_settle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .iclk_active(iclk_active),
    .func_tick(func_tick),
    .settled(settled)
  );

  // control bits; watchdog has none
  always_comb begin
    posted_d = posted_q;
    read_mode_d = read_mode_q;
    if (reg_wr && reg_sel == SEL_SYNC_CONTROL) begin
      posted_d = reg_wdata[POSTED_BIT];
      read_mode_d = reg_wdata[READ_MODE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      posted_q <= POSTED_RESET;
      read_mode_q <= READ_MODE_RESET;
    end else begin
      posted_q <= posted_d;
      read_mode_q <= read_mode_d;
    end
  end

  // shadows refresh only while the interface clock runs
  always_comb begin
    sh_cnt_d = sh_cnt_q;
    sh_cap1_d = sh_cap1_q;
    sh_cap2_d = sh_cap2_q;
    sh_wdt_d = sh_wdt_q;
    if (func_tick && iclk_active) begin
      sh_cnt_d = timer_counter_in;
      sh_cap1_d = capture_first_in;
      sh_cap2_d = capture_second_in;
      sh_wdt_d = watchdog_counter_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh_cnt_q <= VALUE_RESET;
      sh_cap1_q <= VALUE_RESET;
      sh_cap2_q <= VALUE_RESET;
      sh_wdt_q <= VALUE_RESET;
    end else begin
      sh_cnt_q <= sh_cnt_d;
      sh_cap1_q <= sh_cap1_d;
      sh_cap2_q <= sh_cap2_d;
      sh_wdt_q <= sh_wdt_d;
    end
  end

  // read sequencing: which answer fires and from where
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    ans_fire = 1'b0;
    ans_value = rd_data_q;
    ans_stale = unsettled_q;
    unique case (state_q)
      RD_IDLE: begin
        if (reg_rd) begin
          sel_d = reg_sel;
          if (reg_sel == SEL_SYNC_CONTROL) begin
            ans_value = ctrl_view(posted_q, read_mode_q);
            ans_fire = 1'b1;
            ans_stale = 1'b0;
          end else if (reg_sel == SEL_WATCHDOG_COUNTER) begin
            // shadow may be stale after wake
            ans_value = sh_wdt_q;
            ans_fire = 1'b1;
            ans_stale = !settled;
          end else if (!posted_q && read_mode_q) begin
            state_d = RD_WAIT_TICK;
          end else begin
            ans_value = pick(reg_sel, sh_cnt_q, sh_cap1_q, sh_cap2_q, sh_wdt_q);
            ans_fire = 1'b1;
            ans_stale = !settled;
          end
        end
      end
      RD_WAIT_TICK: begin
        // fresh value on next tick, no settle wait
        if (func_tick) begin
          ans_value = pick(sel_q, timer_counter_in, capture_first_in,
                           capture_second_in, watchdog_counter_in);
          ans_fire = 1'b1;
          ans_stale = 1'b0;
          state_d = RD_ANSWER;
        end
      end
      RD_ANSWER: begin
        state_d = RD_IDLE;
      end
      default: state_d = RD_IDLE;
    endcase
    // busy also covers the RD_ANSWER cycle, in which the non-posted answer is valid
    busy_d = (state_d != RD_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= RD_IDLE;
      sel_q <= SEL_TIMER_COUNTER;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      busy_q <= busy_d;
    end
  end

  // answer register: data and stale flag hold until the next answer
  always_comb begin
    rd_data_d = rd_data_q;
    unsettled_d = unsettled_q;
    rd_valid_d = ans_fire;
    if (ans_fire) begin
      rd_data_d = ans_value;
      unsettled_d = ans_stale;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_q <= VALUE_RESET;
      rd_valid_q <= 1'b0;
      unsettled_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      unsettled_q <= unsettled_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_unsettled = unsettled_q;
  assign busy = busy_q;
endmodule // timer_posted_read_sync

// File: logic/timer_sync_pkg.sv
/*
  Shared constants for the timer read-synchronization block: register
  selects, control field positions, reset values and wake settle counts.
  Assumes one interface clock core_clk; functional clock edges arrive as
  single-cycle ticks that are synchronous to it.
*/
// Summary of operation
// - posted-mode timer reads right after interface clock wake may return stale values.
// - non-posted timer reads after wake return correct values, no extra wait needed.
// - watchdog counter reads right after interface clock wake may return stale values.
// - watchdog is always posted; no control switches it to non-posted.
// - on write-only instances the sync control register always reads zero.
package timer_sync_pkg;
  localparam int DATA_W = 32;
  localparam int SEL_W = 3;
  // register selects on the access port
  localparam logic [SEL_W-1:0] SEL_TIMER_COUNTER = 3'h0;
  localparam logic [SEL_W-1:0] SEL_CAPTURE_FIRST = 3'h1;
  localparam logic [SEL_W-1:0] SEL_CAPTURE_SECOND = 3'h2;
  localparam logic [SEL_W-1:0] SEL_WATCHDOG_COUNTER = 3'h3;
  localparam logic [SEL_W-1:0] SEL_SYNC_CONTROL = 3'h4;
  // sync_interface_control fields
  localparam int POSTED_BIT = 2;
  localparam int READ_MODE_BIT = 3;
  localparam logic POSTED_RESET = 1'b1;
  localparam logic READ_MODE_RESET = 1'b0;
  // wake settle: interface cycles, then functional ticks
  localparam logic [1:0] WAKE_IFACE_CYCLES = 2'h2;
  localparam logic [1:0] WAKE_FUNC_TICKS = 2'h1;
  localparam logic [DATA_W-1:0] VALUE_RESET = 32'h0;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT_TICK,
    RD_ANSWER
  } rd_state_type;
endpackage

// File: logic/wake_settle.sv
/*
  Wake settle tracker: watches the interface clock run indication and
  reports when resynchronized shadows are trustworthy again.
  Assumes iclk_active and func_tick are synchronous to core_clk.
*/
module wake_settle
  import timer_sync_pkg::*;
(
  input wire logic core_clk, // interface clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic iclk_active, // interface clock running
  input wire logic func_tick, // one functional clock edge
  output logic settled // shadows safe to read
);
  logic active_q, active_d;
  logic [1:0] iface_cnt_q, iface_cnt_d;
  logic [1:0] tick_cnt_q, tick_cnt_d;
  logic settled_q, settled_d;

  always_comb begin
    active_d = iclk_active;
    iface_cnt_d = iface_cnt_q;
    tick_cnt_d = tick_cnt_q;
    settled_d = settled_q;
    if (!iclk_active) begin
      settled_d = 1'b0;
      iface_cnt_d = 2'h0;
      tick_cnt_d = 2'h0;
    end else if (!active_q) begin
      // wake edge: restart the settle window
      settled_d = 1'b0;
      iface_cnt_d = 2'h1;
      tick_cnt_d = 2'h0;
    end else if (!settled_q) begin
      // two iface cycles plus one tick
      if (iface_cnt_q < WAKE_IFACE_CYCLES) begin
        iface_cnt_d = iface_cnt_q + 2'h1;
      end else if (func_tick) begin
        tick_cnt_d = tick_cnt_q + 2'h1;
        if (tick_cnt_q + 2'h1 >= WAKE_FUNC_TICKS) begin
          settled_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      iface_cnt_q <= 2'h0;
      tick_cnt_q <= 2'h0;
      settled_q <= 1'b0;
    end else begin
      active_q <= active_d;
      iface_cnt_q <= iface_cnt_d;
      tick_cnt_q <= tick_cnt_d;
      settled_q <= settled_d;
    end
  end

  assign settled = settled_q;
endmodule // wake_settle

// File: tb/host_model.sv
/* host on the register port: reads and the non-posted setup;
   tasks are called by the testbench, one request at a time */
module host_model
  import timer_sync_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic func_tick, // tick
  input wire logic [DATA_W-1:0] rd_data, // answer
  input wire logic rd_valid, // strobe
  input wire logic rd_unsettled, // stale
  output logic reg_rd, // read
  output logic reg_wr, // write
  output logic [SEL_W-1:0] reg_sel, // select
  output logic [DATA_W-1:0] reg_wdata // data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_sel = 3'h7;
    reg_wdata = 32'h0;
  end
  task automatic set_nonposted();
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_sel <= SEL_SYNC_CONTROL;
    reg_wdata <= 32'h8;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= 32'hf7;
  endtask
  task automatic rd(input logic [SEL_W-1:0] s, output logic [DATA_W-1:0] d, output logic u);
    int n;
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 64);
    d = (rd_valid === 1'b1) ? rd_data : 'x;
    u = rd_unsettled;
    reg_sel <= ~s;
  endtask
  task automatic settle_wait();
    int n;
    repeat (2) @(posedge core_clk);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (func_tick !== 1'b1 && n < 64);
  endtask
endmodule // host_model

// File: tb/timer_posted_read_sync_props.sv
/* port assertions for the timer read-sync block;
   bound to every instance, reads its ports only */
module timer_posted_read_sync_props
  import timer_sync_pkg::*;
#(
  parameter bit READ_MODE_WRITE_ONLY = 1'b0 // write-only control
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic iclk_active, // wake
  input wire logic func_tick, // tick
  input wire logic reg_rd, // read
  input wire logic [SEL_W-1:0] reg_sel, // select
  input wire logic [DATA_W-1:0] rd_data, // data
  input wire logic rd_valid, // strobe
  input wire logic rd_unsettled, // stale
  input wire logic busy // pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic take = reg_rd && !busy;
  wdog_posted_a: assert property (take && reg_sel == SEL_WATCHDOG_COUNTER |=> rd_valid && !busy)
    else $error("watchdog answer late");
  data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved");
  flag_hold_a: assert property (!rd_valid |-> $stable(rd_unsettled))
    else $error("stale flag moved");
  wake_stale_a: assert property ($rose(iclk_active) && take
    && reg_sel == SEL_WATCHDOG_COUNTER |=> rd_unsettled) else $error("wake read not flagged");
  np_wait_a: assert property (busy && !rd_valid && !func_tick |=> !rd_valid)
    else $error("answer before tick");
  np_done_a: assert property (busy && !rd_valid && func_tick |=> rd_valid && !rd_unsettled)
    else $error("non-posted answer wrong");
  busy_drop_a: assert property (busy && rd_valid |=> !busy)
    else $error("busy stuck");
  ctrl_zero_a: assert property (take && reg_sel == SEL_SYNC_CONTROL
    |=> rd_valid && (!READ_MODE_WRITE_ONLY || rd_data == '0)) else $error("control not zero");
endmodule // timer_posted_read_sync_props

bind timer_posted_read_sync timer_posted_read_sync_props #(
  .READ_MODE_WRITE_ONLY(READ_MODE_WRITE_ONLY)
) props (.*);

// File: tb/timer_posted_read_sync_tb.sv
/* testbench for the timer read-sync block, write-only control instance
   plus a readable one in lockstep; live values and ticks driven here,
   host model on the port */
module timer_posted_read_sync_tb
  import timer_sync_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic iclk_active = 1'b1;
  logic func_tick = 1'b0;
  logic [DATA_W-1:0] timer_counter_in = 32'h11;
  logic [DATA_W-1:0] capture_first_in = 32'h22;
  logic [DATA_W-1:0] capture_second_in = 32'h33;
  logic [DATA_W-1:0] watchdog_counter_in = 32'h44;
  logic reg_rd, reg_wr, rd_valid, rd_unsettled, busy;
  logic [SEL_W-1:0] reg_sel;
  logic [DATA_W-1:0] reg_wdata, rd_data;
  int failures = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  timer_posted_read_sync #(.READ_MODE_WRITE_ONLY(1'b1)) DUT (.*);
  host_model host (.*);
  logic [DATA_W-1:0] rw_rd_data;
  timer_posted_read_sync #(.READ_MODE_WRITE_ONLY(1'b0)) DUT_rw (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .iclk_active(iclk_active),
    .func_tick(func_tick),
    .timer_counter_in(timer_counter_in),
    .capture_first_in(capture_first_in),
    .capture_second_in(capture_second_in),
    .watchdog_counter_in(watchdog_counter_in),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_sel(reg_sel),
    .reg_wdata(reg_wdata),
    .rd_data(rw_rd_data),
    .rd_valid(),
    .rd_unsettled(),
    .busy()
  );
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse_tick();
    @(posedge core_clk);
    func_tick <= 1'b1;
    @(posedge core_clk);
    func_tick <= 1'b0;
  endtask
  // stop the clock, read at wake, then read again once settled
  task automatic wake_read(input logic [SEL_W-1:0] s, output logic u0,
    output logic [DATA_W-1:0] d1, output logic u1);
    logic [DATA_W-1:0] d0;
    @(posedge core_clk);
    iclk_active <= 1'b0;
    repeat (4) @(posedge core_clk);
    fork
      host.rd(s, d0, u0);
      begin
        @(posedge core_clk);
        iclk_active <= 1'b1;
      end
    join
    fork
      host.settle_wait();
      begin
        repeat (3) @(posedge core_clk);
        pulse_tick();
      end
    join
    host.rd(s, d1, u1);
  endtask
  task automatic test_wake_timer();
    logic u0, u1;
    logic [DATA_W-1:0] d1;
    wake_read(SEL_TIMER_COUNTER, u0, d1, u1);
    check("wake flag", DATA_W'(u0), 32'h1);
    check("settled data", d1, 32'h11);
    check("settled flag", DATA_W'(u1), 32'h0);
  endtask
  task automatic test_wake_wdog();
    logic u0, u1;
    logic [DATA_W-1:0] d1;
    wake_read(SEL_WATCHDOG_COUNTER, u0, d1, u1);
    check("wdog wake flag", DATA_W'(u0), 32'h1);
    check("wdog data", d1, 32'h44);
    check("wdog flag", DATA_W'(u1), 32'h0);
  endtask
  task automatic test_nonposted();
    logic [DATA_W-1:0] d;
    logic u;
    logic [DATA_W-1:0] want [3] = '{32'ha1, 32'hb2, 32'hc3};
    host.rd(SEL_CAPTURE_FIRST, d, u);
    check("posted cap1", d, 32'h22);
    host.rd(SEL_CAPTURE_SECOND, d, u);
    check("posted cap2", d, 32'h33);
    host.rd(SEL_SYNC_CONTROL, d, u);
    check("control reset", d, 32'h0);
    check("rw control reset", rw_rd_data, 32'h4);
    host.set_nonposted();
    timer_counter_in <= 32'ha1;
    capture_first_in <= 32'hb2;
    capture_second_in <= 32'hc3;
    for (int s = 0; s < 3; s++) begin
      fork
        host.rd(SEL_W'(s), d, u);
        begin
          repeat (4) @(posedge core_clk);
          check("busy", DATA_W'(busy), 32'h1);
          pulse_tick();
        end
      join
      check("live value", d, want[s]);
      check("live flag", DATA_W'(u), 32'h0);
    end
    host.rd(SEL_WATCHDOG_COUNTER, d, u);
    check("wdog posted", d, 32'h44);
    host.rd(SEL_SYNC_CONTROL, d, u);
    check("control", d, 32'h0);
    check("rw control", rw_rd_data, 32'h8);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    test_wake_timer();
    test_wake_wdog();
    test_nonposted();
    final_report();
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule // timer_posted_read_sync_tb
